/* File: rtl/mpw_pkg.sv */
// constants for the motor protection and watchdog control block
// assumes a single 40 MHz system clock and an 8-bit register port
package mpw_pkg;
    localparam int unsigned CLK_KHZ          = 40000;   // system clock in kHz
    localparam int unsigned ADDR_W           = 8;
    localparam int unsigned DATA_W           = 8;

    localparam logic [7:0] ADDR_WDOG_CTRL    = 8'h10;   // watchdog_protection_control
    localparam logic [7:0] ADDR_PWM_WIDTH    = 8'h11;   // pwm_width_setting
    localparam logic [7:0] ADDR_MAIN_CTRL    = 8'h12;   // main_control_register
    localparam logic [7:0] ADDR_STATUS       = 8'h13;   // status flags

    localparam logic [7:0] WDOG_CTRL_RESET   = 8'h00;
    localparam logic [7:0] PWM_WIDTH_RESET   = 8'h00;
    localparam logic [7:0] MAIN_CTRL_RESET   = 8'h00;

    // watchdog_protection_control fields
    localparam int unsigned BIT_OS_LATCH     = 7;
    localparam int unsigned BIT_OT_LATCH     = 6;
    localparam int unsigned BIT_LINK_CHECK   = 4;
    localparam int unsigned BIT_WD_ENABLE    = 3;
    localparam int unsigned BIT_WD_CLEAR     = 2;
    localparam int unsigned BIT_WD_PERIOD    = 0;       // two bits

    // main_control_register fields
    localparam int unsigned BIT_WIDTH_OVR    = 0;
    localparam int unsigned BIT_COAST        = 1;

    // status fields
    localparam int unsigned BIT_ST_OVERTEMP  = 7;
    localparam int unsigned BIT_ST_OPENSHORT = 5;
    localparam int unsigned BIT_ST_WDOG      = 1;

    // watchdog periods per select code, in ms and in system clock cycles
    localparam int unsigned WD_T0_MS         = 250;
    localparam int unsigned WD_T1_MS         = 500;
    localparam int unsigned WD_T2_MS         = 1000;
    localparam int unsigned WD_T3_MS         = 2000;
    localparam int unsigned WD_T0_CYC        = WD_T0_MS * CLK_KHZ;
    localparam int unsigned WD_T1_CYC        = WD_T1_MS * CLK_KHZ;
    localparam int unsigned WD_T2_CYC        = WD_T2_MS * CLK_KHZ;
    localparam int unsigned WD_T3_CYC        = WD_T3_MS * CLK_KHZ;
endpackage

/* File: rtl/mpw_wdog.sv */
// watchdog counter with four selectable periods
// assumes clear is a one-cycle pulse from the register file
module mpw_wdog #(
    parameter int unsigned T0_CYC = mpw_pkg::WD_T0_CYC,
    parameter int unsigned T1_CYC = mpw_pkg::WD_T1_CYC,
    parameter int unsigned T2_CYC = mpw_pkg::WD_T2_CYC,
    parameter int unsigned T3_CYC = mpw_pkg::WD_T3_CYC
) (
    input  wire logic       clk_sys_i,  // system clock
    input  wire logic       rstn_i,     // async reset, active low
    input  wire logic       enable_i,   // watchdog running
    input  wire logic       clear_i,    // restart pulse
    input  wire logic [1:0] period_i,   // period select
    output logic            expired_o   // sticky timeout
);
    import mpw_pkg::*;

    logic [31:0] count;
    logic [31:0] limit;

    always_comb
    begin
        unique case (period_i)
            2'h0: limit = T0_CYC - 32'h1;
            2'h1: limit = T1_CYC - 32'h1;
            2'h2: limit = T2_CYC - 32'h1;
            2'h3: limit = T3_CYC - 32'h1;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            count <= 32'h0;
        else if (!enable_i || clear_i || count >= limit)
            count <= 32'h0;
        else
            count <= count + 32'h1;
    end

    // expiry wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            expired_o <= 1'b0;
        else if (enable_i && count >= limit)
            expired_o <= 1'b1;
        else if (clear_i || !enable_i)
            expired_o <= 1'b0;
    end
endmodule

/* File: rtl/mpw_ctl.sv */
// motor protection latches, watchdog and pwm width control
// assumes a serial front end delivering decoded byte writes and read addresses;
// fault and coast inputs are synchronous to the system clock
// Functional notes
// - open/short latch select: resume or hold off
// - overtemp unlatched: restore pwm when cleared
// - overtemp latched: pwm off until release
// - release by coast pin fall or bit pulse
// - two-bit field selects watchdog period
// - override enable selects width register duty
// - width code linear, 0 none, 255 full
// - readable watchdog expired flag
// - readable overtemp and open/short flags
module mpw_ctl #(
    parameter int unsigned WD_T0 = mpw_pkg::WD_T0_CYC,
    parameter int unsigned WD_T1 = mpw_pkg::WD_T1_CYC,
    parameter int unsigned WD_T2 = mpw_pkg::WD_T2_CYC,
    parameter int unsigned WD_T3 = mpw_pkg::WD_T3_CYC
) (
    input  wire logic                        clk_sys_i,        // system clock
    input  wire logic                        rstn_i,           // async reset, low
    input  wire logic                        reg_wr_i,         // write strobe
    input  wire logic [mpw_pkg::ADDR_W-1:0] reg_addr_i,       // register address
    input  wire logic [mpw_pkg::DATA_W-1:0] reg_wdata_i,      // write data
    output logic      [mpw_pkg::DATA_W-1:0] reg_rdata_o,      // read data, next cycle
    input  wire logic                        overtemp_i,       // thermal sense below trip
    input  wire logic                        open_short_i,     // clock-set/thermal pin fault
    input  wire logic                        coast_pin_i,      // coast/restart pin
    input  wire logic [7:0]                  duty_pin_code_i,  // digitised duty pin
    output logic                             pwm_enable_o,     // pwm outputs allowed
    output logic      [7:0]                  duty_code_o,      // selected duty, linear
    output logic                             link_check_en_o,  // serial check enable
    output logic                             wdog_timeout_o    // watchdog expired
);
    import mpw_pkg::*;

    logic [7:0] wdog_ctrl;
    logic [7:0] pwm_width;
    logic [7:0] main_ctrl;
    logic       wd_clear;
    logic       ot_latched;
    logic       os_latched;
    logic       coast_pin_q;
    logic       coast_bit_q;
    logic       release_evt;
    logic       wd_expired;
    logic       next_pwm_enable;
    logic       pin_fall;
    logic       bit_fall;
    logic [7:0] status_word;
    logic [7:0] next_duty_code;

    // write decode shared by every writable register
    function automatic logic hit(input logic [7:0] a);
        return reg_wr_i && (reg_addr_i == a);
    endfunction

    // clear bit acts as a pulse and never stays set
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            wdog_ctrl <= WDOG_CTRL_RESET;
        else if (hit(ADDR_WDOG_CTRL))
            wdog_ctrl <= reg_wdata_i & ~(8'h01 << BIT_WD_CLEAR);
    end

    // registered so the count restarts one edge after the write
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            wd_clear <= 1'b0;
        else
            wd_clear <= hit(ADDR_WDOG_CTRL) && reg_wdata_i[BIT_WD_CLEAR];
    end

    // every code is a legal duty, stored as written
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pwm_width <= PWM_WIDTH_RESET;
        else if (hit(ADDR_PWM_WIDTH))
            pwm_width <= reg_wdata_i;
    end

    // only override and coast bits exist, the rest read zero
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            main_ctrl <= MAIN_CTRL_RESET;
        else if (hit(ADDR_MAIN_CTRL))
            main_ctrl <= reg_wdata_i & 8'h03;
    end

    // release edges: pin falling, or control bit written 1 then 0
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            coast_pin_q <= 1'b0;
            coast_bit_q <= 1'b0;
        end
        else
        begin
            coast_pin_q <= coast_pin_i;
            coast_bit_q <= main_ctrl[BIT_COAST];
        end
    end

    // a pin held low releases once; only the falling edge counts
    assign pin_fall    = coast_pin_q && !coast_pin_i;
    assign bit_fall    = coast_bit_q && !main_ctrl[BIT_COAST];
    assign release_evt = pin_fall || bit_fall;

    // a fault still present at release keeps the latch set
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ot_latched <= 1'b0;
        else if (overtemp_i && wdog_ctrl[BIT_OT_LATCH])
            ot_latched <= 1'b1;
        else if (release_evt)
            ot_latched <= 1'b0;
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            os_latched <= 1'b0;
        else if (open_short_i && wdog_ctrl[BIT_OS_LATCH])
            os_latched <= 1'b1;
        else if (release_evt)
            os_latched <= 1'b0;
    end

    // unlatched faults gate pwm only while present
    assign next_pwm_enable = !overtemp_i && !open_short_i
                           && !ot_latched && !os_latched;

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pwm_enable_o <= 1'b0;
        else
            pwm_enable_o <= next_pwm_enable;
    end

    // no scaling: the pin code already spans the same 0..255 range
    always_comb
    begin
        if (main_ctrl[BIT_WIDTH_OVR])
            next_duty_code = pwm_width;
        else
            next_duty_code = duty_pin_code_i;
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            duty_code_o <= 8'h00;
        else
            duty_code_o <= next_duty_code;
    end

    // passed on only; the serial front end does the check
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            link_check_en_o <= 1'b0;
        else
            link_check_en_o <= wdog_ctrl[BIT_LINK_CHECK];
    end

    // period codes 0..3: 250 ms, 500 ms, 1 s, 2 s at the nominal clock
    mpw_wdog #(
        .T0_CYC (WD_T0),
        .T1_CYC (WD_T1),
        .T2_CYC (WD_T2),
        .T3_CYC (WD_T3)
    ) u_wdog (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .enable_i  (wdog_ctrl[BIT_WD_ENABLE]),
        .clear_i   (wd_clear),
        .period_i  (wdog_ctrl[BIT_WD_PERIOD +: 2]),
        .expired_o (wd_expired)
    );

    // one cycle behind the status bit, which reads the raw flag
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            wdog_timeout_o <= 1'b0;
        else
            wdog_timeout_o <= wd_expired;
    end

    // live condition or held latch, so a latched trip stays visible
    always_comb
    begin
        status_word                   = 8'h00;
        status_word[BIT_ST_OVERTEMP]  = overtemp_i || ot_latched;
        status_word[BIT_ST_OPENSHORT] = open_short_i || os_latched;
        status_word[BIT_ST_WDOG]      = wd_expired;
    end

    // read data is registered; unmapped addresses read zero
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            reg_rdata_o <= 8'h00;
        else
        begin
            reg_rdata_o <= 8'h00;
            unique case (reg_addr_i)
                ADDR_WDOG_CTRL: reg_rdata_o <= wdog_ctrl;
                ADDR_PWM_WIDTH: reg_rdata_o <= pwm_width;
                ADDR_MAIN_CTRL: reg_rdata_o <= main_ctrl;
                ADDR_STATUS:    reg_rdata_o <= status_word;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

/* File: test/mpw_monitor.sv */
// port assertions for mpw_ctl
// bound to mpw_ctl; shadows the writable registers from the write port
module mpw_monitor
(
    input wire logic       clk_sys_i,       // clock
    input wire logic       rstn_i,          // reset
    input wire logic       reg_wr_i,        // strobe
    input wire logic [7:0] reg_addr_i,      // address
    input wire logic [7:0] reg_wdata_i,     // data
    input wire logic       overtemp_i,      // hot
    input wire logic       open_short_i,    // pin fault
    input wire logic       coast_pin_i,     // coast
    input wire logic [7:0] duty_pin_code_i, // pin duty
    input wire logic       pwm_enable_o,    // pwm on
    input wire logic [7:0] duty_code_o,     // duty
    input wire logic       wdog_timeout_o   // expired
);
    timeunit 1ns / 100ps;
    import mpw_pkg::*;
    logic [7:0] ctl, mctl, wid, sel;
    logic       ok, lat, rel_bit, pin_q;
    assign sel = mctl[BIT_WIDTH_OVR] ? wid : duty_pin_code_i;
    assign ok  = !overtemp_i && !open_short_i;
    always_ff @(posedge clk_sys_i or negedge rstn_i)
        if (!rstn_i)
            {ctl, mctl, wid} <= '0;
        else if (reg_wr_i)
            case (reg_addr_i)
                ADDR_WDOG_CTRL: ctl <= reg_wdata_i;
                ADDR_MAIN_CTRL: mctl <= reg_wdata_i;
                ADDR_PWM_WIDTH: wid <= reg_wdata_i;
                default: ;
            endcase
    // reference latch: a fault in latched mode sets it, either release frees it
    always_ff @(posedge clk_sys_i or negedge rstn_i)
        if (!rstn_i)
            {lat, rel_bit, pin_q} <= 3'b000;
        else
        begin
            rel_bit <= mctl[BIT_COAST];
            pin_q   <= coast_pin_i;
            if ((overtemp_i && ctl[BIT_OT_LATCH]) || (open_short_i && ctl[BIT_OS_LATCH]))
                lat <= 1'b1;
            else if ((pin_q && !coast_pin_i) || (rel_bit && !mctl[BIT_COAST]))
                lat <= 1'b0;
        end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    sequence s_rel;
        $fell(coast_pin_i) ##0 ok [*3];
    endsequence
    // no release event of either kind may reach the latch here
    sequence s_trip;
        ctl[BIT_OT_LATCH] && overtemp_i && !(reg_wr_i && reg_addr_i == ADDR_MAIN_CTRL)
            ##1 (ok && $stable(coast_pin_i)
            && !(reg_wr_i && reg_addr_i == ADDR_MAIN_CTRL)) [*3];
    endsequence
    AST_OT_OFF: assert property (overtemp_i |=> !pwm_enable_o)
        else $error("pwm on after overtemp");
    AST_OS_OFF: assert property (open_short_i |=> !pwm_enable_o)
        else $error("pwm on after open short");
    AST_LATCH_HOLD: assert property (s_trip |-> !pwm_enable_o)
        else $error("latch released early");
    AST_RELEASE: assert property (s_rel |=> pwm_enable_o)
        else $error("coast fall did not release");
    AST_UNLATCHED: assert property ((!lat && ok && !ctl[BIT_OS_LATCH]
        && !ctl[BIT_OT_LATCH]) [*2] |=> pwm_enable_o) else $error("pwm not restored");
    AST_DUTY: assert property ($past(rstn_i) |-> duty_code_o == $past(sel))
        else $error("duty source wrong");
    AST_WD_MIN: assert property ($rose(wdog_timeout_o) |-> $past(ctl[3], 8))
        else $error("watchdog expired too soon");
    // a fresh timeout keeps an expiry off the clear edge; needs periods of 9 or more
    AST_WD_CLR: assert property (reg_wr_i && reg_addr_i == ADDR_WDOG_CTRL
        && reg_wdata_i[BIT_WD_CLEAR] && wdog_timeout_o && !$past(wdog_timeout_o, 6)
        |-> ##[2:3] !wdog_timeout_o) else $error("clear ignored");
endmodule
bind mpw_ctl mpw_monitor i_mon (.clk_sys_i, .rstn_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .overtemp_i, .open_short_i, .coast_pin_i, .duty_pin_code_i, .pwm_enable_o, .duty_code_o,
    .wdog_timeout_o);

/* File: test/mpw_host.sv */
// host model for the register port of mpw_ctl
// drives after the falling edge; the block takes writes at the rising edge
module mpw_host
(
    input  wire logic       clk_sys_i, // clock
    output logic            wr_o,      // strobe
    output logic      [7:0] addr_o,    // address
    output logic      [7:0] wdata_o,   // data
    output logic            rd_o       // read marker
);
    timeunit 1ns / 100ps;
    initial
    begin
        {wr_o, rd_o} = 2'b00;
        {addr_o, wdata_o} = 16'h0000;
    end
    // data inverted afterwards so a stale byte is never mistaken for a write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        {wr_o, addr_o, wdata_o} = {1'b1, a, d};
        @(negedge clk_sys_i);
        {wr_o, wdata_o} = {1'b0, ~d};
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys_i);
        {rd_o, addr_o} = {1'b1, a};
        @(negedge clk_sys_i);
        rd_o = 1'b0;
    endtask
endmodule

/* File: test/mpw_ctl_tb.sv */
// bench for mpw_ctl with watchdog periods cut to 8/16/32/64 cycles
// pins driven here at the falling edge; registers through mpw_host
module mpw_ctl_tb;
    timeunit 1ns / 100ps;
    import mpw_pkg::*;
    logic       clk = 1'b0, rstn = 1'b0, ot = 1'b0, os = 1'b0, coast = 1'b1;
    logic       wr, rd_go, rd_seen = 1'b0, pwm, link, wdto;
    logic [7:0] pin = 8'h00, addr, wdata, rdata, duty, v;
    logic [7:0] q[$];
    integer     seed = 32'hB4D92E91;
    int         errors = 0, checked = 0, n;
    int         per[4] = '{8, 16, 32, 64};
    always #12.5 clk = ~clk;
    mpw_host i_host (.clk_sys_i(clk), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
        .rd_o(rd_go));
    mpw_ctl #(.WD_T0(8), .WD_T1(16), .WD_T2(32), .WD_T3(64)) i_dut (.clk_sys_i(clk),
        .rstn_i(rstn), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .overtemp_i(ot), .open_short_i(os), .coast_pin_i(coast),
        .duty_pin_code_i(pin), .pwm_enable_o(pwm), .duty_code_o(duty),
        .link_check_en_o(link), .wdog_timeout_o(wdto));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        i_host.rd(a);
    endtask
    task cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task stop_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
        rd_seen <= rd_go;
    always @(negedge clk)
        if (rd_seen)
            chk(rdata, q.pop_front());
    initial
    begin
        cyc(5000);
        errors++;
        stop_test();
    end
    initial
    begin
        cyc(5);
        rstn = 1'b1;
        rd(ADDR_WDOG_CTRL, WDOG_CTRL_RESET);
        rd(ADDR_MAIN_CTRL, MAIN_CTRL_RESET);
        rd(8'h3F, 8'h00);
        v = 8'($random(seed)) & 8'hD3;
        i_host.wr(ADDR_WDOG_CTRL, v);
        i_host.wr(ADDR_MAIN_CTRL, 8'hFC);
        i_host.wr(ADDR_STATUS, 8'hFF);
        rd(ADDR_WDOG_CTRL, v);
        chk(8'(link), 8'(v[BIT_LINK_CHECK]));
        rd(ADDR_MAIN_CTRL, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            pin = 8'($random(seed));
            i_host.wr(ADDR_PWM_WIDTH, v);
            i_host.wr(ADDR_MAIN_CTRL, 8'h01);
            rd(ADDR_PWM_WIDTH, v);
            chk(duty, v);
            i_host.wr(ADDR_MAIN_CTRL, 8'h00);
            cyc(2);
            chk(duty, pin);
        end
        i_host.wr(ADDR_WDOG_CTRL, 8'h00);
        ot = 1'b1;
        rd(ADDR_STATUS, 8'h80);
        chk(8'(pwm), 8'h00);
        ot = 1'b0;
        cyc(2);
        chk(8'(pwm), 8'h01);
        i_host.wr(ADDR_WDOG_CTRL, 8'h40);
        ot = 1'b1;
        cyc(1);
        ot = 1'b0;
        cyc(4);
        chk(8'(pwm), 8'h00);
        coast = 1'b0;
        cyc(4);
        chk(8'(pwm), 8'h01);
        i_host.wr(ADDR_WDOG_CTRL, 8'h80);
        os = 1'b1;
        cyc(1);
        os = 1'b0;
        rd(ADDR_STATUS, 8'h20);
        i_host.wr(ADDR_MAIN_CTRL, 8'h02);
        cyc(3);
        chk(8'(pwm), 8'h00);
        i_host.wr(ADDR_MAIN_CTRL, 8'h00);
        cyc(3);
        chk(8'(pwm), 8'h01);
        for (int p = 0; p < 4; p++)
        begin
            i_host.wr(ADDR_WDOG_CTRL, 8'(8 + p));
            n = 1;
            while (wdto !== 1'b1 && n < 200)
            begin
                cyc(1);
                n++;
            end
            chk(8'(n >= per[p] && n <= per[p] + 5), 8'h01);
            rd(ADDR_STATUS, 8'h02);
            i_host.wr(ADDR_WDOG_CTRL, 8'(12 + p));
            cyc(3);
            chk(8'(wdto), 8'h00);
            i_host.wr(ADDR_WDOG_CTRL, 8'h00);
        end
        cyc(2);
        stop_test();
    end
endmodule
